/* cpk_top.sv */
// Top of the clock output gate and skew block with its AXI4-Lite registers
`default_nettype none

module cpk_top
  import cpk_pkg::*;
#(
  parameter int unsigned NB = cpk_pkg::NUM_BANKS
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Enable and gate pins
  input  wire logic          global_out_en_n,
  input  wire logic          second_out_en_x_n,
  input  wire logic          second_out_en_y_n,
  input  wire logic          sync_clock_gate,
  // Clock outputs
  output logic [NB-1:0]      bank_out_a,
  output logic [NB-1:0]      bank_out_a_oe_n,
  output logic [NB-1:0]      bank_out_b,
  output logic [NB-1:0]      bank_out_b_oe_n
);
  import cpk_pkg::*;

  // ==========================================================================
  // Declarations
  logic [3:0]        pin_meta_q;
  logic [3:0]        pin_sync_q;
  logic              half_q;
  logic              tick;
  logic [31:0]       ctrl_q;
  logic [31:0]       bank_q [NB];
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              do_write;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       rd_word;
  logic [2*NB-1:0]   drive_all;
  logic [2*NB-1:0]   run_all;

  cpk_bank_if bif [NB] ();

  // ==========================================================================
  // Pin synchronisers, two flops before any logic reads the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 4'h3;
      pin_sync_q <= 4'h3;
    end else begin
      pin_meta_q <= {sync_clock_gate, second_out_en_y_n, second_out_en_x_n, global_out_en_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================================
  // Unit tick: every cycle in fine mode every second cycle in coarse
  // mode, which is the extra halving ahead of the dividers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  assign tick = ctrl_q[CTRL_COARSE_BIT] ? half_q : 1'b1;

  // ==========================================================================
  // Bank instances; every bank gets its own configuration word, shared by its outputs A and B
  for (genvar b = 0; b < NB; b++) begin : g_bank
    assign bif[b].tick     = tick;
    assign bif[b].bypass   = ctrl_q[CTRL_BYPASS_BIT];
    assign bif[b].int_fb   = ctrl_q[CTRL_INTFB_BIT];
    assign bif[b].fb_skew  = ctrl_q[CTRL_FBSKEW_LSB +: SKEW_W];
    assign bif[b].cfg      = bank_q[b];
    assign bif[b].glb_en_n = pin_sync_q[0];
    assign bif[b].en_x_n   = pin_sync_q[1];
    assign bif[b].en_y_n   = pin_sync_q[2];
    assign bif[b].gate_in  = pin_sync_q[3];
    assign drive_all[2*b +: 2] = bif[b].drive_st;
    assign run_all[2*b +: 2]   = bif[b].run_st;

    cpk_bank u_bank (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .bif        (bif[b]),
      .out_a      (bank_out_a[b]),
      .out_a_oe_n (bank_out_a_oe_n[b]),
      .out_b      (bank_out_b[b]),
      .out_b_oe_n (bank_out_b_oe_n[b])
    );
  end

  // ==========================================================================
  // Address decode helpers
  function automatic logic is_bank(input logic [7:0] a);
    is_bank = (a >= BANK_BASE_OFS) && (a < BANK_BASE_OFS + 8'(4 * NB)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  assign wr_hit = (awaddr_q == CTRL_OFS) || is_bank(awaddr_q);
  assign rd_hit = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == STATUS_OFS) || is_bank(s_axi_araddr);

  // ==========================================================================
  // Write channels: address and data are taken in either order, then the
  // write happens once both are held and no response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      awaddr_q  <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  assign do_write = !awready_q && !wready_q && !bvalid_q;

  // Write response, error for unmapped or read-only offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
    end else if (do_write && awaddr_q == CTRL_OFS) begin
      ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
    end
  end

  // Bank configuration registers; the bank raises dividers below DIV_MIN to DIV_MIN, other divider limits are left to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int b = 0; b < NB; b++) begin
        bank_q[b] <= BCFG_RST;
      end
    end else if (do_write && is_bank(awaddr_q)) begin
      for (int b = 0; b < NB; b++) begin
        if (awaddr_q[7:2] == 6'((BANK_BASE_OFS >> 2) + 8'(b))) begin
          bank_q[b] <= merge(bank_q[b], wdata_q, wstrb_q) & BCFG_MASK;
        end
      end
    end
  end

  // ==========================================================================
  // Read path, one read in flight; status shows live drive and gate state
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == CTRL_OFS) begin
      rd_word = ctrl_q;
    end else if (s_axi_araddr == STATUS_OFS) begin
      rd_word[STAT_DRIVE_LSB +: 2*NB] = drive_all;
      rd_word[STAT_RUN_LSB +: 2*NB]   = run_all;
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (s_axi_araddr[7:2] == 6'((BANK_BASE_OFS >> 2) + 8'(b))) begin
          rd_word = bank_q[b];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_hit ? rd_word : 32'h0000_0000;
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ==========================================================================
  // Bus outputs, all straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

`default_nettype wire

/* cpk_pkg.sv */
// Package of constants and types for the clock output gate and skew block
`default_nettype none

package cpk_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_BANKS   = 5;
  localparam int unsigned SKEW_W      = 4;
  localparam int unsigned DIV_W       = 7;
  localparam int unsigned SKEW_MAX    = 15;
  localparam int unsigned LINE_DEPTH  = 2 * SKEW_MAX + 1;
  localparam int unsigned TAP_W       = 5;
  localparam int unsigned COARSE_DIV  = 2;
  localparam int unsigned DIV_MIN     = 2;
  localparam int unsigned DIV_MAX     = 80;

  // ==========================================================================
  // Unit delay figures, fine and coarse, in ps and in units per VCO period
  localparam int unsigned FINE_TU_MIN_PS   = 156;
  localparam int unsigned FINE_TU_MAX_PS   = 390;
  localparam int unsigned COARSE_TU_MIN_PS = 312;
  localparam int unsigned COARSE_TU_MAX_PS = 780;
  localparam int unsigned FINE_PER_VCO     = 8;
  localparam int unsigned COARSE_PER_VCO   = 4;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] BANK_BASE_OFS = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_COARSE_BIT  = 0;
  localparam int unsigned CTRL_BYPASS_BIT  = 1;
  localparam int unsigned CTRL_INTFB_BIT   = 2;
  localparam int unsigned CTRL_FBSKEW_LSB  = 4;
  localparam logic [31:0] CTRL_MASK        = 32'h0000_00F7;
  localparam logic [31:0] CTRL_RST         = 32'h0000_0000;

  // Bank configuration fields
  localparam int unsigned BCFG_EN_A_LSB   = 0;
  localparam int unsigned BCFG_EN_B_LSB   = 2;
  localparam int unsigned BCFG_POL_A_BIT  = 4;
  localparam int unsigned BCFG_POL_B_BIT  = 5;
  localparam int unsigned BCFG_DIFF_BIT   = 6;
  localparam int unsigned BCFG_GATE_BIT   = 7;
  localparam int unsigned BCFG_SKEW_A_LSB = 8;
  localparam int unsigned BCFG_SKEW_B_LSB = 12;
  localparam int unsigned BCFG_DIV_LSB    = 16;
  localparam logic [31:0] BCFG_MASK       = 32'h007F_FFFF;
  localparam logic [31:0] BCFG_RST        = 32'h0008_0000;

  // Status register fields
  localparam int unsigned STAT_DRIVE_LSB  = 0;
  localparam int unsigned STAT_RUN_LSB    = 16;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================================
  // Per-output enable behaviour
  typedef enum logic [1:0] {
    EN_ALWAYS = 2'b00,
    EN_NEVER  = 2'b01,
    EN_ON_X   = 2'b10,
    EN_ON_Y   = 2'b11
  } cpk_en_mode_t;

endpackage

`default_nettype wire

/* cpk_bank_if.sv */
// Interface carrying configuration and status between control and one bank
`default_nettype none

interface cpk_bank_if;
  import cpk_pkg::*;

  logic                tick;
  logic                bypass;
  logic                int_fb;
  logic [SKEW_W-1:0]   fb_skew;
  logic [31:0]         cfg;
  logic                glb_en_n;
  logic                en_x_n;
  logic                en_y_n;
  logic                gate_in;
  logic [1:0]          drive_st;
  logic [1:0]          run_st;

  modport ctl  (output tick, bypass, int_fb, fb_skew, cfg, glb_en_n, en_x_n, en_y_n, gate_in,
                input  drive_st, run_st);
  modport bank (input  tick, bypass, int_fb, fb_skew, cfg, glb_en_n, en_x_n, en_y_n, gate_in,
                output drive_st, run_st);
endinterface

`default_nettype wire

/* cpk_skew_line.sv */
// Tapped delay line that delays one clock by a chosen number of unit ticks
`default_nettype none

module cpk_skew_line #(
  parameter int unsigned DEPTH = 31,
  parameter int unsigned SEL_W = 5
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Line control
  input  wire logic             tick,
  input  wire logic             din,
  input  wire logic [SEL_W-1:0] sel,
  // Delayed clock
  output logic                  tap
);

  logic [DEPTH-1:0] line_q;
  logic [SEL_W-1:0] sel_q;

  // ==========================================================================
  // Shift one stage per unit tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_q <= '0;
    end else if (tick) begin
      line_q <= {line_q[DEPTH-2:0], din};
    end
  end

  // Tap moves only while old and new taps both sit low, so no glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= '0;
    end else if (!line_q[sel_q] && !line_q[sel]) begin
      sel_q <= sel;
    end
  end

  assign tap = line_q[sel_q];

endmodule

`default_nettype wire

/* cpk_bank.sv */
// One output bank: divider, two skew lines, gating, polarity and enables
`default_nettype none

module cpk_bank (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Configuration and status
  cpk_bank_if.bank  bif,
  // Output pins
  output logic      out_a,
  output logic      out_a_oe_n,
  output logic      out_b,
  output logic      out_b_oe_n
);
  import cpk_pkg::*;

  logic [DIV_W-1:0]  div_cnt_q;
  logic [DIV_W-1:0]  div_val;
  logic              base_q;
  logic              diff;
  logic [1:0]        pol;
  logic [1:0]        tap;
  logic [1:0]        run_q;
  logic [1:0]        out_q;
  logic [1:0]        oe_n_q;
  logic [1:0]        drive;
  logic [SKEW_W-1:0] skew [2];
  cpk_en_mode_t      mode [2];

  // ==========================================================================
  // Field extraction; a differential pair shares skew and enable, B takes the inverse of polarity A
  assign diff    = bif.cfg[BCFG_DIFF_BIT];
  assign div_val = (bif.cfg[BCFG_DIV_LSB +: DIV_W] < DIV_W'(DIV_MIN)) ? DIV_W'(DIV_MIN)
                                                                      : bif.cfg[BCFG_DIV_LSB +: DIV_W];
  assign skew[0] = bif.cfg[BCFG_SKEW_A_LSB +: SKEW_W];
  assign skew[1] = diff ? skew[0] : bif.cfg[BCFG_SKEW_B_LSB +: SKEW_W];
  assign mode[0] = cpk_en_mode_t'(bif.cfg[BCFG_EN_A_LSB +: 2]);
  assign mode[1] = diff ? mode[0] : cpk_en_mode_t'(bif.cfg[BCFG_EN_B_LSB +: 2]);
  assign pol[0]  = bif.cfg[BCFG_POL_A_BIT];
  assign pol[1]  = diff ? ~pol[0] : bif.cfg[BCFG_POL_B_BIT];

  // ==========================================================================
  // Output divider counts unit ticks, so coarse halving reaches it too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= '0;
      base_q    <= 1'b0;
    end else if (bif.tick) begin
      div_cnt_q <= (div_cnt_q >= div_val - DIV_W'(1)) ? '0 : div_cnt_q + DIV_W'(1);
      base_q    <= (div_cnt_q < (div_val >> 1));
    end
  end

  // ==========================================================================
  // Per-output skew, gating and enable
  for (genvar o = 0; o < 2; o++) begin : g_out
    logic [TAP_W-1:0] sel;

    // Internal feedback shifts every tap back by the feedback skew
    always_comb begin
      if (bif.bypass) begin
        sel = '0;
      end else if (bif.int_fb) begin
        sel = TAP_W'(skew[o]) + TAP_W'(SKEW_MAX) - TAP_W'(bif.fb_skew);
      end else begin
        sel = TAP_W'(skew[o]);
      end
    end

    cpk_skew_line #(
      .DEPTH (LINE_DEPTH),
      .SEL_W (TAP_W)
    ) u_line (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (bif.tick),
      .din     (base_q),
      .sel     (sel),
      .tap     (tap[o])
    );

    // Enable decode from global, secondary pins and mode
    always_comb begin
      case (mode[o])
        EN_ALWAYS: drive[o] = 1'b1;
        EN_NEVER:  drive[o] = 1'b0;
        EN_ON_X:   drive[o] = !bif.en_x_n;
        EN_ON_Y:   drive[o] = !bif.en_y_n;
        default:   drive[o] = 1'b0;
      endcase
      drive[o] = drive[o] && !bif.glb_en_n;
    end

    // Gate state changes only while delayed clock is low, so no runt
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        run_q[o] <= 1'b0;
      end else if (!tap[o]) begin
        run_q[o] <= bif.cfg[BCFG_GATE_BIT] ? bif.gate_in : 1'b1;
      end
    end

    // Output level with polarity; stopped clock rests at polarity level
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_q[o]  <= 1'b0;
        oe_n_q[o] <= 1'b1;
      end else begin
        out_q[o]  <= pol[o] ^ (tap[o] & run_q[o]);
        oe_n_q[o] <= !drive[o];
      end
    end
  end

  assign out_a        = out_q[0];
  assign out_b        = out_q[1];
  assign out_a_oe_n   = oe_n_q[0];
  assign out_b_oe_n   = oe_n_q[1];
  assign bif.drive_st = ~oe_n_q;
  assign bif.run_st   = run_q;

endmodule

`default_nettype wire

/* cpk_top_sva.sv */
// Checker of bus handshakes and global enable at the block top
`default_nettype none
module cpk_top_sva #(
  parameter int unsigned NB = 5
) (
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Bus handshakes
  input wire logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid, s_axi_rready,
  // Pins
  input wire logic          global_out_en_n,
  input wire logic [NB-1:0] bank_out_a_oe_n,
  input wire logic [NB-1:0] bank_out_b_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // One domain, so one clock and one disable
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin passes two sync flops and the output flop
  a_glb_hiz: assert property (global_out_en_n [*3] |=> (&bank_out_a_oe_n && &bank_out_b_oe_n))
    else $error("output driven while global enable off");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready too early");
  a_b_soon: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_free: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  a_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_free: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
endmodule
bind cpk_top cpk_top_sva #(.NB(NB)) u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .global_out_en_n, .bank_out_a_oe_n, .bank_out_b_oe_n);
`default_nettype wire

/* cpk_board.sv */
// Board load model: pull-down pads and shortest high pulse per output A
`default_nettype none
module cpk_board #(
  parameter int unsigned NB = 5
) (
  // Clock and clear
  input wire logic          aclk,
  input wire logic          clr,
  // Block pins
  input wire logic [NB-1:0] out_a,
  input wire logic [NB-1:0] oe_a_n,
  // Board view
  output logic [NB-1:0]     pad_a,
  output logic [7:0]        min_hi [NB]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] run [NB];
  // Released pad falls to the pull-down, never keeps the last level
  assign pad_a = ~oe_a_n & out_a;
  // Clear only while pads rest low, else a cut pulse reads as a runt
  always @(posedge aclk) begin
    for (int i = 0; i < NB; i++) begin
      if (clr) begin
        min_hi[i] <= 8'hFF;
        run[i]    <= 8'h00;
      end else if (pad_a[i]) begin
        run[i] <= run[i] + 8'h01;
      end else begin
        if (run[i] != 8'h00 && run[i] < min_hi[i]) min_hi[i] <= run[i];
        run[i] <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

/* clock_output_gate_skew_tb.sv */
// Self-checking bench of the clock output gate and skew block
`default_nettype none
module clock_output_gate_skew_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpk_pkg::*;
  typedef struct packed {logic g, x, y; cpk_en_mode_t m; logic e;} cpk_row_t;
  // ======
  logic                 aclk = 1'b0, aresetn = 1'b0, clr = 1'b1;
  logic [7:0]           s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]          s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0]           s_axi_wstrb = 4'hF;
  logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic                 global_out_en_n = 1, second_out_en_x_n = 1, second_out_en_y_n = 1, sync_clock_gate = 1;
  logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, la, hb, oe, bad;
  logic [1:0]           s_axi_bresp, s_axi_rresp, rs;
  logic [NUM_BANKS-1:0] bank_out_a, bank_out_a_oe_n, bank_out_b, bank_out_b_oe_n, pad_a;
  logic [7:0]           min_hi [NUM_BANKS];
  int                   err_total = 0, n_compared = 0, d, r2;
  // Enable table: pins, mode, expected oe_n
  cpk_row_t rows [8] = '{'{1'b1,1'b0,1'b0,EN_ALWAYS,1'b1}, '{1'b0,1'b0,1'b0,EN_NEVER,1'b1},
    '{1'b0,1'b1,1'b1,EN_ALWAYS,1'b0}, '{1'b0,1'b0,1'b1,EN_ON_X,1'b0}, '{1'b0,1'b1,1'b0,EN_ON_X,1'b1},
    '{1'b0,1'b1,1'b0,EN_ON_Y,1'b0}, '{1'b0,1'b0,1'b1,EN_ON_Y,1'b1}, '{1'b1,1'b0,1'b0,EN_ON_X,1'b1}};
  cpk_top #(.NB(NUM_BANKS)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_out_en_n, .second_out_en_x_n, .second_out_en_y_n,
    .sync_clock_gate, .bank_out_a, .bank_out_a_oe_n, .bank_out_b, .bank_out_b_oe_n);
  cpk_board #(.NB(NUM_BANKS)) u_board (.aclk, .clr, .out_a(bank_out_a), .oe_a_n(bank_out_a_oe_n), .pad_a, .min_hi);
  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end
  // ======
  task automatic test_done;
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // Bus write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k == 50) begin
      err_total++;
      test_done;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 50) begin
      err_total++;
      test_done;
    end
  endtask
  // Cycles from a rise of output A to the next rise of output B
  task automatic meas(input int b, output int v);
    logic pa, pb, go;
    int c;
    go = 0;
    c = 0;
    v = -1;
    pa = bank_out_a[b];
    pb = bank_out_b[b];
    for (int k = 0; k < 400 && v < 0; k++) begin
      @(negedge aclk);
      if (!pa && bank_out_a[b]) begin
        go = 1;
        c = 0;
      end else if (go) c++;
      if (go && !pb && bank_out_b[b]) v = c;
      pa = bank_out_a[b];
      pb = bank_out_b[b];
    end
  endtask
  // ======
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS, rv, rs);
    chk("ctrl_rst", CTRL_RST, rv);
    rd(BANK_BASE_OFS, rv, rs);
    chk("bank_rst", BCFG_RST, rv);
    rd(8'h80, rv, rs);
    chk("unmapped", {RESP_SLVERR, 30'h0000_0000}, {rs, rv[29:0]});
    wr(STATUS_OFS, 32'hFFFF_FFFF, 4'hF, rs);
    chk("ro_write", 32'(RESP_SLVERR), 32'(rs));
    wr(CTRL_OFS, 32'hFFFF_FFFF, 4'hF, rs);
    rd(CTRL_OFS, rv, rs);
    chk("ctrl_mask", CTRL_MASK, rv);
    wr(CTRL_OFS, 32'h0000_0000, 4'hF, rs);
    wr(BANK_BASE_OFS + 8'h04, 32'hFFFF_FFFF, 4'h1, rs);
    rd(BANK_BASE_OFS + 8'h04, rv, rs);
    chk("strobe", 32'h0008_00FF, rv);
    // Enable table on bank 0, both outputs
    foreach (rows[i]) begin
      wr(BANK_BASE_OFS, {28'h0008_000, rows[i].m, rows[i].m}, 4'hF, rs);
      @(posedge aclk);
      global_out_en_n <= rows[i].g;
      second_out_en_x_n <= rows[i].x;
      second_out_en_y_n <= rows[i].y;
      repeat (5) @(posedge aclk);
      @(negedge aclk);
      chk("oe_n", {2{rows[i].e}}, {bank_out_b_oe_n[0], bank_out_a_oe_n[0]});
    end
    // Bank 0 gated, B inverted; bank 2 ungated
    wr(BANK_BASE_OFS, 32'h0008_00A0, 4'hF, rs);
    @(posedge aclk);
    global_out_en_n <= 1'b0;
    sync_clock_gate <= 1'b0;
    repeat (20) @(posedge aclk);
    {la, hb, oe, r2} = {3'b010, 32'd0};
    d = bank_out_a[2];
    for (int k = 0; k < 24; k++) begin
      @(negedge aclk);
      la |= bank_out_a[0];
      hb &= bank_out_b[0];
      oe |= bank_out_a_oe_n[0] | bank_out_b_oe_n[0];
      if (bank_out_a[2] && d == 0) r2++;
      d = bank_out_a[2];
    end
    chk("gated", 32'h0000_0002, {29'h0, la, hb, oe});
    chk("ungated", 32'd3, 32'(r2));
    rd(STATUS_OFS, rv, rs);
    chk("status", 32'h03F0_03FF, rv);
    @(posedge aclk);
    sync_clock_gate <= 1'b1;
    clr <= 1'b0;
    repeat (40) @(posedge aclk);
    sync_clock_gate <= 1'b0;
    repeat (30) @(posedge aclk);
    chk("min_high", 32'd4, 32'(min_hi[0]));
    // Skew A 0 and B 15 on bank 3
    wr(8'h1C, 32'h0028_F000, 4'hF, rs);
    repeat (100) @(posedge aclk);
    meas(3, d);
    chk("skew_fine", 32'd15, 32'(d));
    wr(CTRL_OFS, 32'h0000_0001, 4'hF, rs);
    wr(8'h1C, 32'h0014_F000, 4'hF, rs);
    repeat (100) @(posedge aclk);
    meas(3, d);
    chk("skew_coarse", 32'd30, 32'(d));
    wr(CTRL_OFS, 32'h0000_0064, 4'hF, rs);
    wr(8'h1C, 32'h0028_F000, 4'hF, rs);
    repeat (100) @(posedge aclk);
    meas(3, d);
    chk("skew_fb", 32'd15, 32'(d));
    wr(CTRL_OFS, 32'h0000_0002, 4'hF, rs);
    repeat (100) @(posedge aclk);
    meas(3, d);
    chk("skew_bypass", 32'd0, 32'(d));
    // Differential bank 4 ignores skew B; bypass off so skew counts
    wr(CTRL_OFS, 32'h0000_0000, 4'hF, rs);
    wr(BANK_BASE_OFS + 8'h10, 32'h0008_9340, 4'hF, rs);
    repeat (60) @(posedge aclk);
    bad = 1'b0;
    repeat (16) @(negedge aclk) bad |= (bank_out_b[4] === bank_out_a[4]);
    chk("diff", 32'd0, 32'(bad));
    // Reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("oe_rst", 32'h0000_03FF, 32'({bank_out_b_oe_n, bank_out_a_oe_n}));
    rd(BANK_BASE_OFS, rv, rs);
    chk("bank_rst2", BCFG_RST, rv);
    test_done;
  end
endmodule
`default_nettype wire
